// ==== src/usb_baud.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_baud
  import usb_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [1:0] prescale_sel,
  input wire logic [2:0] rate_sel,
  output logic sample_tick
);
  logic [3:0] pre_cnt_reg;
  logic [6:0] rate_cnt_reg;
  logic [3:0] pre_max;
  logic pre_tick;
  logic [6:0] rate_mask;
  assign pre_max = (prescale_sel == 2'h0) ? USB_DIV_P1 : // RL16
                   (prescale_sel == 2'h1) ? USB_DIV_P3 :
                   (prescale_sel == 2'h2) ? USB_DIV_P4 : USB_DIV_P13;
  assign pre_tick = (pre_cnt_reg >= pre_max);
  assign rate_mask = 7'((8'h01 << rate_sel) - 8'h01); // RL18
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pre_cnt_reg <= 4'h0;
      rate_cnt_reg <= 7'h00;
      sample_tick <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_tick ? 4'h0 : pre_cnt_reg + 4'h1;
      if (pre_tick) begin
        rate_cnt_reg <= ((rate_cnt_reg & rate_mask) == rate_mask) ? 7'h00 : rate_cnt_reg + 7'h01;
      end
      sample_tick <= pre_tick && ((rate_cnt_reg & rate_mask) == rate_mask); // RL21
    end
  end
endmodule : usb_baud
`default_nettype wire

// ==== src/usb_pkg.sv ====
// Overview of operation
// [RL1] transmit-complete sets when transmit-empty is set and nothing shifts out
// [RL2] transmit-complete with its enable raises the interrupt request
// [RL3] transmit-complete clears after status read seeing it, then data write
// [RL4] reset forces transmit-complete to one
// [RL5] receive-full sets when a character moves into the data buffer
// [RL6] receive-full with receiver enable raises the interrupt request
// [RL7] receive-full clears after status read seeing it, then data read
// [RL8] idle sets after ten or eleven consecutive one samples
// [RL9] idle with its enable requests interrupt; clears by status then data read
// [RL10] character completing while receive-full set sets overrun, data kept
// [RL11] overrun with receiver enable requests interrupt; clears by status, data read
// [RL12] noise flag marks noise in buffered character; status then data read clears
// [RL13] zero sampled at stop position sets framing error
// [RL14] overrun and framing error together set only overrun
// [RL15] framing error clears after status read then data read
// [RL16] prescale codes 00,01,10,11 divide by 1,3,4,13
// [RL17] reset clears the prescale select
// [RL18] rate select divides prescaled clock by two to the field value
// [RL19] rate select is not changed by reset
// [RL20] one rate setting serves receiver and transmitter
// [RL21] generator output is the sample clock; bit time is sixteen samples
// [RL22] three start verification samples; two zeros accept, not all zero sets noise
// [RL23] character length select picks nine or eight bits, sets idle and break runs
// [RL24] data access without prior flag-seeing status read leaves flags unchanged
// [RL25] status flags are read only; status writes do nothing
package usb_pkg;
  localparam logic [3:0] USB_OFS_STATUS = 4'h0;
  localparam logic [3:0] USB_OFS_DATA = 4'h4;
  localparam logic [3:0] USB_OFS_RATE = 4'h8;
  localparam logic [3:0] USB_OFS_CTRL = 4'hc;
  // status bits
  localparam int USB_ST_TXE = 7;
  localparam int USB_ST_DONE = 6;
  localparam int USB_ST_RXF = 5;
  localparam int USB_ST_IDLE = 4;
  localparam int USB_ST_OR = 3;
  localparam int USB_ST_NOISE = 2;
  localparam int USB_ST_FRM = 1;
  // control bits
  localparam int USB_CT_TXIE = 7;
  localparam int USB_CT_DONEIE = 6;
  localparam int USB_CT_RXIE = 5;
  localparam int USB_CT_IDLEIE = 4;
  localparam int USB_CT_TE = 3;
  localparam int USB_CT_RE = 2;
  localparam int USB_CT_M = 1;
  localparam int USB_CT_SBK = 0;
  localparam int USB_RATE_PS_LSB = 4;
  localparam logic [7:0] USB_CTRL_RESET = 8'h00;
  localparam logic [1:0] USB_PS_RESET = 2'h0;
  localparam logic [3:0] USB_DIV_P1 = 4'h0;
  localparam logic [3:0] USB_DIV_P3 = 4'h2;
  localparam logic [3:0] USB_DIV_P4 = 4'h3;
  localparam logic [3:0] USB_DIV_P13 = 4'hc;
  localparam logic [3:0] USB_SAMPLES_PER_BIT = 4'hf;
  localparam logic [3:0] USB_IDLE_RUN_8 = 4'ha;
  localparam logic [3:0] USB_IDLE_RUN_9 = 4'hb;
  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [7:0] dat;
  } usb_req_type;
endpackage : usb_pkg

// ==== src/usb_rxbuf.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_rxbuf
  import usb_pkg::*;
(
  input wire logic clock,
  input wire logic load,
  input wire logic [8:0] din,
  output logic [8:0] dout
);
  logic [8:0] mem_reg;
  // buffer is unaffected by reset
  always_ff @(posedge clock) begin
    if (load) begin
      mem_reg <= din;
    end
    dout <= load ? din : mem_reg;
  end
endmodule : usb_rxbuf
`default_nettype wire

// ==== src/usb_top.sv ====
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module usb_top
  import usb_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic rx_in,
  output logic tx_out,
  output logic irq_out
);
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} usb_rx_state_type;
  typedef enum {TX_OFF, TX_PRE, TX_IDLE, TX_SHIFT, TX_BREAK} usb_tx_state_type;

  usb_req_type req;
  logic acc, hit_st, hit_dat, hit_rate, hit_ctrl, mapped, take;
  logic lane0;
  assign req = '{adr: wb_adr_i, we: wb_we_i, dat: wb_dat_i[7:0]};
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit_st = (req.adr == USB_OFS_STATUS);
  assign hit_dat = (req.adr == USB_OFS_DATA);
  assign hit_rate = (req.adr == USB_OFS_RATE);
  assign hit_ctrl = (req.adr == USB_OFS_CTRL);
  assign mapped = hit_st | hit_dat | hit_rate | hit_ctrl;
  assign take = acc && mapped;
  assign lane0 = wb_sel_i[0];

  logic st_rd, dat_rd, dat_wr, rate_wr, ctrl_wr;
  assign st_rd = take && !req.we && hit_st;
  assign dat_rd = take && !req.we && hit_dat;
  assign dat_wr = take && req.we && hit_dat && lane0;
  assign rate_wr = take && req.we && hit_rate && lane0;
  assign ctrl_wr = take && req.we && hit_ctrl && lane0;

  logic [7:0] ctrl_reg;
  logic [1:0] ps_reg;
  logic [2:0] rs_reg;
  logic txe_reg, done_reg, rxf_reg, idle_reg, or_reg, noise_reg, frm_reg;
  logic [7:0] status;
  logic seen_done_reg, seen_txe_reg, seen_rx_reg;
  assign status = {txe_reg, done_reg, rxf_reg, idle_reg, or_reg, noise_reg, frm_reg, 1'b0};

  // bus answers and control registers
  logic [8:0] rx_buf;
  logic [31:0] rd_mux;
  assign rd_mux = hit_st ? {24'h0, status} :
                  hit_dat ? {24'h0, rx_buf[7:0]} :
                  hit_rate ? {24'h0, 2'h0, ps_reg, 1'b0, rs_reg} :
                  hit_ctrl ? {24'h0, ctrl_reg} : 32'h0;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= take;
      wb_err_o <= acc && !mapped;
      wb_dat_o <= (take && !req.we) ? rd_mux : 32'h0;
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg <= USB_CTRL_RESET;
      ps_reg <= USB_PS_RESET; // RL17
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= req.dat;
      end
      if (rate_wr) begin
        ps_reg <= req.dat[USB_RATE_PS_LSB+1:USB_RATE_PS_LSB];
      end
    end
  end
  // rate select keeps its contents across reset
  always_ff @(posedge clock) begin
    if (rate_wr) begin
      rs_reg <= req.dat[2:0]; // RL19
    end
  end

  logic tick;
  usb_baud u_baud (
    .clock(clock),
    .reset_n(reset_n),
    .prescale_sel(ps_reg),
    .rate_sel(rs_reg),
    .sample_tick(tick) // RL20
  );

  logic nine;
  assign nine = ctrl_reg[USB_CT_M]; // RL23

  // receiver
  usb_rx_state_type rx_st_reg;
  logic [3:0] rx_ph_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_sh_reg;
  logic [2:0] ver_reg;
  logic rx_noise_reg;
  logic [3:0] one_run_reg;
  logic idle_armed_reg;
  logic [1:0] zeros;
  logic [3:0] last_bit, idle_run;
  assign zeros = 2'(!ver_reg[0]) + 2'(!ver_reg[1]) + 2'(!ver_reg[2]);
  assign last_bit = nine ? 4'h8 : 4'h7;
  assign idle_run = nine ? USB_IDLE_RUN_9 : USB_IDLE_RUN_8;
  logic rx_en, char_done, stop_ok, sample_mid, ver_pt;
  assign rx_en = ctrl_reg[USB_CT_RE];
  assign sample_mid = tick && (rx_ph_reg == 4'h7);
  assign ver_pt = tick && (rx_ph_reg == 4'h3 || rx_ph_reg == 4'h5 || rx_ph_reg == 4'h7);
  assign char_done = (rx_st_reg == RX_STOP) && sample_mid;
  assign stop_ok = rx_in;
  logic buf_load, set_or, set_frm, set_noise, set_idle;
  assign buf_load = char_done && !rxf_reg; // RL5
  assign set_or = char_done && rxf_reg; // RL10
  assign set_frm = buf_load && !stop_ok; // RL13 RL14
  assign set_noise = buf_load && (rx_noise_reg || !stop_ok); // RL12
  assign set_idle = tick && rx_in && idle_armed_reg && (rx_st_reg == RX_IDLE) &&
                    (one_run_reg == idle_run - 4'h1) && (rx_ph_reg == USB_SAMPLES_PER_BIT);

  usb_rxbuf u_rxbuf (
    .clock(clock),
    .load(buf_load),
    .din(rx_sh_reg),
    .dout(rx_buf)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rx_st_reg <= RX_IDLE;
      rx_ph_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      ver_reg <= 3'h7;
      rx_noise_reg <= 1'b0;
      one_run_reg <= 4'h0;
      idle_armed_reg <= 1'b0;
    end else if (!rx_en) begin
      rx_st_reg <= RX_IDLE;
      one_run_reg <= 4'h0;
    end else if (tick) begin
      rx_ph_reg <= rx_ph_reg + 4'h1;
      case (rx_st_reg)
        RX_IDLE: begin
          // bit-time counting of consecutive ones
          if (!rx_in) begin
            rx_st_reg <= RX_START;
            rx_ph_reg <= 4'h1;
            ver_reg <= 3'h7;
            one_run_reg <= 4'h0;
          end else if (rx_ph_reg == USB_SAMPLES_PER_BIT) begin
            if (one_run_reg == idle_run - 4'h1) begin // RL8
              idle_armed_reg <= 1'b0;
            end else begin
              one_run_reg <= one_run_reg + 4'h1;
            end
          end
        end
        RX_START: begin
          if (ver_pt) begin
            ver_reg <= {ver_reg[1:0], rx_in};
          end
          if (rx_ph_reg == 4'h8) begin
            if (zeros >= 2'h2) begin // RL22
              rx_st_reg <= RX_DATA;
              rx_noise_reg <= (zeros != 2'h3);
              rx_bit_reg <= 4'h0;
              rx_ph_reg <= 4'h9;
            end else begin
              rx_st_reg <= RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (rx_ph_reg == 4'h7) begin
            rx_sh_reg <= nine ? {rx_in, rx_sh_reg[8:1]} : {1'b0, rx_in, rx_sh_reg[7:1]};
            if (rx_bit_reg == last_bit) begin
              rx_st_reg <= RX_STOP;
            end
            rx_bit_reg <= rx_bit_reg + 4'h1;
          end
        end
        RX_STOP: begin
          if (rx_ph_reg == 4'h7) begin
            rx_st_reg <= RX_IDLE;
            rx_ph_reg <= 4'h8;
            idle_armed_reg <= 1'b1;
          end
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  // transmitter: bit time is sixteen sample ticks
  usb_tx_state_type tx_st_reg;
  logic [3:0] tx_ph_reg;
  logic [3:0] tx_cnt_reg;
  logic [10:0] tx_sh_reg;
  logic [7:0] tx_hold_reg;
  logic bit_end;
  assign bit_end = tick && (tx_ph_reg == USB_SAMPLES_PER_BIT); // RL21
  logic [3:0] frame_len;
  assign frame_len = nine ? 4'hb : 4'ha;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tx_st_reg <= TX_OFF;
      tx_ph_reg <= 4'h0;
      tx_cnt_reg <= 4'h0;
      tx_sh_reg <= 11'h7ff;
      tx_hold_reg <= 8'h00;
      tx_out <= 1'b1;
    end else begin
      if (dat_wr) begin
        tx_hold_reg <= req.dat;
      end
      if (tick) begin
        tx_ph_reg <= tx_ph_reg + 4'h1;
      end
      case (tx_st_reg)
        TX_OFF: begin
          tx_out <= 1'b1;
          if (ctrl_reg[USB_CT_TE]) begin
            tx_st_reg <= TX_PRE;
            tx_cnt_reg <= 4'h0;
          end
        end
        TX_PRE: begin
          tx_out <= 1'b1;
          if (bit_end) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == frame_len - 4'h1) begin
              tx_st_reg <= TX_IDLE;
            end
          end
        end
        TX_IDLE: begin
          tx_out <= 1'b1;
          if (!ctrl_reg[USB_CT_TE]) begin
            tx_st_reg <= TX_OFF;
          end else if (ctrl_reg[USB_CT_SBK] && bit_end) begin
            tx_st_reg <= TX_BREAK;
            tx_cnt_reg <= 4'h0;
          end else if (!txe_reg && bit_end) begin
            tx_sh_reg <= {2'h3, tx_hold_reg, 1'b0};
            tx_st_reg <= TX_SHIFT;
            tx_cnt_reg <= 4'h0;
          end
        end
        TX_SHIFT: begin
          tx_out <= tx_sh_reg[0];
          if (bit_end) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == frame_len - 4'h1) begin
              tx_st_reg <= TX_IDLE;
            end
          end
        end
        TX_BREAK: begin
          tx_out <= 1'b0;
          if (bit_end) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == frame_len - 4'h1) begin
              tx_st_reg <= ctrl_reg[USB_CT_SBK] ? TX_BREAK : TX_IDLE;
              tx_cnt_reg <= 4'h0;
            end
          end
        end
        default: tx_st_reg <= TX_OFF;
      endcase
    end
  end
  logic txe_load, tx_busy;
  assign txe_load = (tx_st_reg == TX_IDLE) && !txe_reg && bit_end &&
                    ctrl_reg[USB_CT_TE] && !ctrl_reg[USB_CT_SBK];
  assign tx_busy = (tx_st_reg == TX_PRE) || (tx_st_reg == TX_SHIFT) ||
                   (tx_st_reg == TX_BREAK) || txe_load;

  // status flags: sets win over clears, but a transmit-empty clear blocks the transmit-complete set; status writes are ignored RL25
  logic done_clr, txe_clr, rx_clr;
  assign done_clr = dat_wr && seen_done_reg; // RL3 RL24
  assign txe_clr = dat_wr && seen_txe_reg;
  assign rx_clr = dat_rd && seen_rx_reg; // RL7 RL24
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      txe_reg <= 1'b1;
      done_reg <= 1'b1; // RL4
      rxf_reg <= 1'b0;
      idle_reg <= 1'b0;
      or_reg <= 1'b0;
      noise_reg <= 1'b0;
      frm_reg <= 1'b0;
      seen_done_reg <= 1'b0;
      seen_txe_reg <= 1'b0;
      seen_rx_reg <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (st_rd) begin
        seen_done_reg <= done_reg;
        seen_txe_reg <= txe_reg;
        seen_rx_reg <= rxf_reg | idle_reg | or_reg | noise_reg | frm_reg;
      end else begin
        if (dat_wr) begin
          seen_done_reg <= 1'b0;
          seen_txe_reg <= 1'b0;
        end
        if (dat_rd) begin
          seen_rx_reg <= 1'b0;
        end
      end
      txe_reg <= txe_load | (txe_reg & !txe_clr);
      done_reg <= (txe_reg && !tx_busy && !txe_clr) | (done_reg & !done_clr); // RL1
      rxf_reg <= buf_load | (rxf_reg & !rx_clr); // RL5 RL7
      idle_reg <= set_idle | (idle_reg & !rx_clr); // RL8 RL9
      or_reg <= set_or | (or_reg & !rx_clr); // RL10 RL11
      noise_reg <= set_noise | (noise_reg & !rx_clr); // RL12
      frm_reg <= set_frm | (frm_reg & !rx_clr); // RL13 RL15
      irq_out <= (done_reg && ctrl_reg[USB_CT_DONEIE]) || // RL2
                 (txe_reg && ctrl_reg[USB_CT_TXIE]) ||
                 (rx_en && (rxf_reg || or_reg) && ctrl_reg[USB_CT_RXIE]) || // RL6 RL11
                 (rx_en && idle_reg && ctrl_reg[USB_CT_IDLEIE]); // RL9
    end
  end
endmodule : usb_top
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import usb_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack, err, rx_line, tx_line, irq;
  int bad_count = 0;
  int check_count = 0;
  int divs[4] = '{1, 3, 4, 13};
  always #50 clock = ~clock;
  usb_top dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .rx_in(rx_line), .tx_out(tx_line), .irq_out(irq));
  usb_remote remote (.clock(clock), .tx_line(tx_line), .rx_line(rx_line));
  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wb(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [31:0] q,
          output logic e);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("bus answer", 1, 0);
      final_report;
    end
    q = dat_o;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task rd(input logic [3:0] a, output logic [31:0] q);
    logic e;
    wb(a, 1'b0, 8'h00, q, e);
  endtask : rd
  task wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    wb(a, 1'b1, d, q, e);
  endtask : wr
  task t_reset_vals;
    logic [31:0] q;
    logic e;
    rd(USB_OFS_STATUS, q);
    chk("status reset", 32'hc0, q);
    rd(USB_OFS_RATE, q);
    chk("prescale reset", 0, {30'h0, q[5:4]});
    wb(4'h2, 1'b1, 8'hff, q, e);
    chk("unmapped err", 1, {31'h0, e});
    wr(USB_OFS_STATUS, 8'h00);
    rd(USB_OFS_STATUS, q);
    chk("status write", 32'hc0, q);
  endtask : t_reset_vals
  task t_tx(input logic [1:0] ps, input logic [2:0] rs, input logic [7:0] d);
    logic [31:0] q;
    int n0, k;
    wr(USB_OFS_RATE, {2'h0, ps, 1'b0, rs});
    rd(USB_OFS_STATUS, q);
    wr(USB_OFS_DATA, d);
    rd(USB_OFS_STATUS, q);
    chk("done after write", 0, {31'h0, q[USB_ST_DONE]});
    n0 = remote.got_count;
    k = 0;
    while (remote.got_count == n0 && k < 40000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 40000) begin
      chk("tx frame", 1, 0);
      final_report;
    end
    chk("tx char", d, remote.got_char);
    chk("bit cycles", 16 * divs[ps] * (1 << rs), remote.got_width);
    repeat (remote.got_width + 4) @(posedge clock);
    rd(USB_OFS_STATUS, q);
    chk("done after frame", 1, {31'h0, q[USB_ST_DONE]});
  endtask : t_tx
  task t_done_irq;
    wr(USB_OFS_CTRL, 8'h48);
    repeat (2) @(posedge clock);
    chk("done irq", 1, {31'h0, irq});
    wr(USB_OFS_CTRL, 8'h08);
  endtask : t_done_irq
  task rx_char(input logic [7:0] d, input logic stop_val);
    remote.send_char(d, stop_val);
    // a zero stop bit reads as a new start edge; let that phantom character end
    repeat (stop_val ? 4 : 200) @(posedge clock);
  endtask : rx_char
  task t_rx;
    logic [31:0] q;
    wr(USB_OFS_RATE, 8'h00);
    remote.bit_cycles = 16;
    wr(USB_OFS_CTRL, 8'h24);
    rx_char(8'ha5, 1'b1);
    rd(USB_OFS_STATUS, q);
    chk("rx full", 1, {31'h0, q[USB_ST_RXF]});
    chk("rx irq", 1, {31'h0, irq});
    rd(USB_OFS_DATA, q);
    chk("rx data", 32'ha5, q);
    rd(USB_OFS_STATUS, q);
    chk("rx full clear", 0, {31'h0, q[USB_ST_RXF]});
    repeat (200) @(posedge clock);
    rd(USB_OFS_STATUS, q);
    chk("idle", 1, {31'h0, q[USB_ST_IDLE]});
    rd(USB_OFS_DATA, q);
    rd(USB_OFS_STATUS, q);
    chk("idle clear", 0, {31'h0, q[USB_ST_IDLE]});
    rd(USB_OFS_DATA, q);
    rx_char(8'h5a, 1'b1);
    rd(USB_OFS_DATA, q);
    rd(USB_OFS_STATUS, q);
    chk("full kept", 1, {31'h0, q[USB_ST_RXF]});
    // second character with bad stop while buffer is still full
    rx_char(8'hc3, 1'b0);
    rd(USB_OFS_STATUS, q);
    chk("overrun", 1, {31'h0, q[USB_ST_OR]});
    chk("framing on overrun", 0, {31'h0, q[USB_ST_FRM]});
    rd(USB_OFS_DATA, q);
    chk("data kept", 32'h5a, q);
    rd(USB_OFS_STATUS, q);
    chk("overrun clear", 0, {31'h0, q[USB_ST_OR]});
    rx_char(8'h0f, 1'b0);
    rd(USB_OFS_STATUS, q);
    chk("framing", 1, {31'h0, q[USB_ST_FRM]});
    chk("noise on bad stop", 1, {31'h0, q[USB_ST_NOISE]});
    rd(USB_OFS_DATA, q);
    rd(USB_OFS_STATUS, q);
    chk("framing clear", 0, {31'h0, q[USB_ST_FRM]});
    chk("noise clear", 0, {31'h0, q[USB_ST_NOISE]});
  endtask : t_rx
  task t_rate_keep;
    logic [31:0] q;
    wr(USB_OFS_RATE, 8'h33);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(USB_OFS_RATE, q);
    chk("rate kept", 32'h3, {29'h0, q[2:0]});
    chk("prescale cleared", 0, {30'h0, q[5:4]});
  endtask : t_rate_keep
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_reset_vals;
    wr(USB_OFS_RATE, 8'h00);
    wr(USB_OFS_CTRL, 8'h08);
    t_tx(2'h0, 3'h0, 8'h35);
    t_done_irq;
    t_tx(2'h1, 3'h0, 8'h6b);
    t_tx(2'h2, 3'h0, 8'ha3);
    t_tx(2'h3, 3'h0, 8'h57);
    t_tx(2'h0, 3'h2, 8'hc9);
    t_tx(2'h0, 3'h7, 8'h1d);
    t_rx;
    t_rate_keep;
    final_report;
  end
endmodule : tb_top
`default_nettype wire

// ==== tb/usb_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_props
  import usb_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic rx_in,
  input wire logic tx_out,
  input wire logic irq_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] ctrl_reg;
  wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire mapped = wb_adr_i[1:0] == 2'h0;
  wire stat_rd = wb_ack_o && !wb_we_i && wb_adr_i == USB_OFS_STATUS;
  wire done_on = wb_dat_o[USB_ST_DONE] && ctrl_reg[USB_CT_DONEIE];
  wire rxf_on = wb_dat_o[USB_ST_RXF] && ctrl_reg[USB_CT_RXIE] && ctrl_reg[USB_CT_RE];
  // shadow of the control register, updated at the accepted write
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg <= 8'h00;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == USB_OFS_CTRL) begin
      ctrl_reg <= wb_dat_i[7:0];
    end
  end
  AST_ANSWER: assert property (taken |=> wb_ack_o ^ wb_err_o)
    else $error("no single answer to a request");
  AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UNMAPPED: assert property (taken && !mapped |=> wb_err_o)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (taken && mapped |=> !wb_err_o)
    else $error("mapped access refused");
  AST_RESET_EXIT: assert property ($rose(reset_n) |-> tx_out && !irq_out && !wb_ack_o)
    else $error("outputs not idle after reset");
  AST_IRQ: assert property (stat_rd && (done_on || rxf_on) |-> ##[0:1] irq_out)
    else $error("enabled flag without interrupt");
  AST_DONE_QUIET: assert property (stat_rd && wb_dat_o[USB_ST_DONE] |-> tx_out && $past(tx_out))
    else $error("transmit complete while line active");
  AST_LOW_BIT: assert property ($fell(tx_out) |-> (!tx_out) [*8])
    else $error("low bit too short");
  AST_HIGH_BIT: assert property ($rose(tx_out) |-> tx_out [*8])
    else $error("high bit too short");
  cover property (stat_rd && wb_dat_o[USB_ST_RXF]);
  cover property (wb_err_o);
  cover property ($rose(irq_out));
endmodule : usb_props
bind usb_top usb_props u_props (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .rx_in(rx_in), .tx_out(tx_out), .irq_out(irq_out));
`default_nettype wire

// ==== tb/usb_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
module usb_remote (
  input wire logic clock,
  input wire logic tx_line,
  output logic rx_line
);
  int bit_cycles = 16;
  int got_count = 0;
  int got_width = 0;
  logic [7:0] got_char = 8'h00;
  initial rx_line = 1'b1;
  // start, eight data bits lsb first, stop
  task automatic send_char(input logic [7:0] d, input logic stop_val);
    logic [9:0] f;
    f = {stop_val, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (bit_cycles) @(posedge clock);
    end
    rx_line <= 1'b1;
  endtask : send_char
  // bit time is taken from the start bit, so data must have lsb set
  always begin
    @(posedge clock iff tx_line === 1'b0);
    got_width = 0;
    while (tx_line === 1'b0) begin
      got_width++;
      @(posedge clock);
    end
    repeat (got_width / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      got_char[i] = tx_line;
      repeat (got_width) @(posedge clock);
    end
    got_count++;
  end
endmodule : usb_remote
`default_nettype wire
